// ---- logic/debp_bus.sv ----
// External program and port bus pin logic of the signal processor
// How it works
// RULE1: Code protect blocks external reads of internal memory
// RULE2: Address lines driven always, released only in reset
// RULE3: Port address on three low address lines
// RULE4: Upper address lines high during port access
// RULE5: Data bus floats except while write strobe low
// RULE6: Data bus also driven on internal peripheral writes
// RULE7: Falling interrupt input edge raises a request
// RULE8: Low non-maskable input interrupts despite global mask; the code raises the request only on a falling edge outside reset
// RULE9: Source select sampled during reset, high means internal
// RULE10: Write strobe low exactly while data driven out; peripheral writes drive data with write strobe high
// RULE11: Read strobe low while capturing data from bus
// RULE12: Reset low holds reset and zeroes program counter
// RULE13: Read and write strobes never asserted together
`timescale 1ns/1ps
`default_nettype none
module debp_bus (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reset_in_n,
  input wire logic int_in_n,
  input wire logic nmi_and_source_select_pin,
  input wire logic code_protect_bit,
  input wire logic global_interrupt_mask,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_port,
  input wire logic req_periph,
  input wire logic [11:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic pc_step,
  input wire logic int_ack,
  input wire logic [15:0] data_line_in,
  output logic [11:0] program_address_line,
  output logic addr_oe,
  output logic [15:0] data_line_out,
  output logic data_oe,
  output logic write_n,
  output logic read_n,
  output logic req_done,
  output logic [15:0] rd_data,
  output logic req_denied,
  output logic int_pending,
  output logic nmi_pending,
  output logic program_source_select,
  output logic cpu_in_reset,
  output logic [11:0] pc
);
  logic [2:0] pins_sync;
  logic rst_pin;
  logic int_pin;
  logic nmi_pin;
  debp_pkg::debp_state_type state_q, state_d;
  logic [11:0] addr_q, addr_d;
  logic [15:0] dout_q, dout_d;
  logic data_oe_q, data_oe_d;
  logic addr_oe_q, addr_oe_d;
  logic wr_n_q, wr_n_d;
  logic rd_n_q, rd_n_d;
  logic done_q, done_d;
  logic deny_q, deny_d;
  logic [15:0] rdat_q, rdat_d;
  logic int_prev_q, int_prev_d;
  logic nmi_prev_q, nmi_prev_d;
  logic int_q, int_d;
  logic nmi_q, nmi_d;
  logic src_q, src_d;
  logic inrst_q, inrst_d;
  logic [11:0] pc_q, pc_d;
  logic [1:0] rd_cnt_q, rd_cnt_d;
  logic [15:0] din_meta_q;
  logic [15:0] din_q;

  // Pins from the board are asynchronous
  debp_sync #(.W(3)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in({reset_in_n, int_in_n, nmi_and_source_select_pin}),
    .pin_sync(pins_sync)
  );
  assign rst_pin = ~pins_sync[2];
  assign int_pin = pins_sync[1];
  assign nmi_pin = pins_sync[0];

  // Read data sampled twice; only meaningful while read strobe low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      din_meta_q <= 16'h0000;
      din_q <= 16'h0000;
    end else begin
      din_meta_q <= data_line_in;
      din_q <= din_meta_q;
    end
  end

  // Bus cycle sequencer: one write strobe cycle; the read strobe is held while data returns
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    dout_d = dout_q;
    data_oe_d = 1'b0;
    wr_n_d = 1'b1;
    rd_n_d = 1'b1;
    done_d = 1'b0;
    deny_d = 1'b0;
    rdat_d = rdat_q;
    rd_cnt_d = rd_cnt_q;
    addr_oe_d = ~rst_pin; // RULE2
    if (rst_pin) begin
      state_d = debp_pkg::ST_IDLE;
      addr_d = debp_pkg::PC_RESET;
      rd_cnt_d = 2'h0;
    end else begin
      case (state_q)
        debp_pkg::ST_IDLE: begin
          addr_d = pc_q;
          if (req_valid && !req_port && !req_write && !src_q && code_protect_bit) begin
            deny_d = 1'b1; // RULE1
            done_d = 1'b1;
          end else if (req_valid) begin
            // Port access: high fill over the port number
            if (req_port) begin
              addr_d = {debp_pkg::PORT_HIGH_FILL, req_addr[2:0]}; // RULE3 RULE4
            end else begin
              addr_d = req_addr;
            end
            dout_d = req_wdata;
            if (req_periph && req_write) begin
              data_oe_d = 1'b1; // RULE6
              state_d = debp_pkg::ST_PERIPH;
            end else if (req_write) begin
              data_oe_d = 1'b1; // RULE5
              wr_n_d = 1'b0; // RULE10 RULE13
              state_d = debp_pkg::ST_WRITE;
            end else begin
              rd_n_d = 1'b0; // RULE11 RULE13
              state_d = debp_pkg::ST_READ;
            end
          end
        end
        debp_pkg::ST_READ: begin
          // Bus data needs two sync flops, so the strobe is held until it is through
          if (rd_cnt_q == debp_pkg::READ_SYNC_WAIT) begin
            rdat_d = din_q; // RULE11
            done_d = 1'b1;
            rd_cnt_d = 2'h0;
            state_d = debp_pkg::ST_IDLE;
          end else begin
            rd_n_d = 1'b0; // RULE11
            rd_cnt_d = rd_cnt_q + 2'h1;
          end
        end
        debp_pkg::ST_WRITE: begin
          done_d = 1'b1;
          state_d = debp_pkg::ST_IDLE;
        end
        debp_pkg::ST_PERIPH: begin
          done_d = 1'b1;
          state_d = debp_pkg::ST_IDLE;
        end
        default: begin
          state_d = debp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= debp_pkg::ST_IDLE;
      addr_q <= debp_pkg::PC_RESET;
      dout_q <= 16'h0000;
      data_oe_q <= 1'b0;
      addr_oe_q <= 1'b0;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      done_q <= 1'b0;
      deny_q <= 1'b0;
      rdat_q <= 16'h0000;
      rd_cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      data_oe_q <= data_oe_d;
      addr_oe_q <= addr_oe_d;
      wr_n_q <= wr_n_d;
      rd_n_q <= rd_n_d;
      done_q <= done_d;
      deny_q <= deny_d;
      rdat_q <= rdat_d;
      rd_cnt_q <= rd_cnt_d;
    end
  end

  // Interrupt edges, strap and program counter; set beats acknowledge
  always_comb begin
    int_prev_d = int_pin;
    nmi_prev_d = nmi_pin;
    int_d = int_q;
    nmi_d = nmi_q;
    src_d = src_q;
    inrst_d = rst_pin;
    pc_d = pc_q;
    if (int_ack) begin
      int_d = 1'b0;
      nmi_d = 1'b0;
    end
    if (rst_pin) begin
      src_d = nmi_pin; // RULE9
      pc_d = debp_pkg::PC_RESET; // RULE12
      int_d = 1'b0;
      nmi_d = 1'b0;
    end else begin
      if (int_prev_q && !int_pin && !global_interrupt_mask) begin
        int_d = 1'b1; // RULE7
      end
      // Strap pin doubles as NMI once out of reset
      if (nmi_prev_q && !nmi_pin) begin
        nmi_d = 1'b1; // RULE8
      end
      if (pc_step) begin
        pc_d = pc_q + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      int_prev_q <= 1'b1;
      nmi_prev_q <= 1'b1;
      int_q <= 1'b0;
      nmi_q <= 1'b0;
      src_q <= 1'b1;
      inrst_q <= 1'b1;
      pc_q <= debp_pkg::PC_RESET;
    end else begin
      int_prev_q <= int_prev_d;
      nmi_prev_q <= nmi_prev_d;
      int_q <= int_d;
      nmi_q <= nmi_d;
      src_q <= src_d;
      inrst_q <= inrst_d;
      pc_q <= pc_d;
    end
  end

  assign program_address_line = addr_q;
  assign addr_oe = addr_oe_q;
  assign data_line_out = dout_q;
  assign data_oe = data_oe_q;
  assign write_n = wr_n_q;
  assign read_n = rd_n_q;
  assign req_done = done_q;
  assign rd_data = rdat_q;
  assign req_denied = deny_q;
  assign int_pending = int_q;
  assign nmi_pending = nmi_q;
  assign program_source_select = src_q;
  assign cpu_in_reset = inrst_q;
  assign pc = pc_q;

  // Checks
  strobes_excl_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(!wr_n_q && !rd_n_q)) else $error("read and write strobes together"); // RULE13
  data_float_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    data_oe_q |-> (!wr_n_q || $past(state_d) == debp_pkg::ST_PERIPH))
    else $error("data driven without write"); // RULE5
  write_drive_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !wr_n_q |-> data_oe_q) else $error("write strobe without data"); // RULE10
  addr_release_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(!rst_pin && !sys_rst) |-> addr_oe_q)
    else $error("address released outside reset"); // RULE2
  port_fill_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(state_q) == debp_pkg::ST_IDLE && $past(req_valid && req_port && !rst_pin))
    |-> program_address_line[11:3] == debp_pkg::PORT_HIGH_FILL)
    else $error("port access without high fill"); // RULE4
  port_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(state_q) == debp_pkg::ST_IDLE && $past(req_valid && req_port && !rst_pin))
    |-> program_address_line[2:0] == $past(req_addr[2:0]))
    else $error("wrong port address"); // RULE3
  pc_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rst_pin |=> pc_q == debp_pkg::PC_RESET) else $error("pc not cleared"); // RULE12
  int_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (int_prev_q && !int_pin && !rst_pin && !global_interrupt_mask) |=> int_q)
    else $error("interrupt edge lost"); // RULE7
  nmi_take_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (nmi_prev_q && !nmi_pin && !rst_pin) |=> nmi_q)
    else $error("nmi not taken"); // RULE8
  protect_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_q == debp_pkg::ST_IDLE && req_valid && !req_port && !req_write && !src_q
     && code_protect_bit && !rst_pin) |=> (rd_n_q && req_denied))
    else $error("protected memory read"); // RULE1
endmodule // debp_bus
`default_nettype wire

// ---- logic/debp_pkg.sv ----
// Package: constants for the external bus pin logic
package debp_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int PORT_W = 3;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [8:0] PORT_HIGH_FILL = 9'h1FF;
  localparam logic [11:0] ROM_LAST = 12'hFFF;
  // Extra read cycles so bus data clears the two sync flops
  localparam logic [1:0] READ_SYNC_WAIT = 2'h2;
  // Bus cycle states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_WRITE = 4'h4,
    ST_PERIPH = 4'h8
  } debp_state_type;
endpackage : debp_pkg

// ---- logic/debp_sync.sv ----
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module debp_sync #(
  parameter int W = 3
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // Idle level of all watched pins is high
  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pin_sync = sync_q;
endmodule // debp_sync
`default_nettype wire

// ---- test/debp_mem_model.sv ----
// Partner model: external program memory and ports on the data bus
`timescale 1ns/1ps
`default_nettype none
module debp_mem_model (
  input wire logic clk_sys,
  input wire logic read_n,
  input wire logic [11:0] program_address_line,
  output logic [15:0] mem_data
);
  logic [15:0] last_q = 16'h0000;
  // Remember the bus so a released bus never repeats stale data
  always @(posedge clk_sys) begin
    last_q <= mem_data;
  end
  // Answer only while the read strobe is low, else a changing pattern
  assign mem_data = !read_n ? {4'hC, program_address_line} : ~last_q;
endmodule // debp_mem_model
`default_nettype wire

// ---- test/dsp_external_bus_pin_logic_test.sv ----
// Testbench for the external bus pin logic
`timescale 1ns/1ps
`default_nettype none
module dsp_external_bus_pin_logic_test;
  typedef struct {logic w, p, ph; logic [11:0] a, ea; logic [15:0] d;} debp_row_type;
  logic clk_sys = 1'h0, sys_rst = 1'h1, reset_in_n = 1'h1, int_in_n = 1'h1, nmi_pin = 1'h1;
  logic protect = 1'h0, mask = 1'h0, req_valid = 1'h0, req_write = 1'h0, req_port = 1'h0;
  logic req_periph = 1'h0, pc_step = 1'h0, int_ack = 1'h0;
  logic [11:0] req_addr = 12'h000;
  logic [15:0] req_wdata = 16'h0000;
  logic [11:0] addr, pc;
  logic addr_oe, data_oe, write_n, read_n, req_done, req_denied, int_p, nmi_p, src, in_rst;
  logic [15:0] data_out, rd_data, mdl_data, bus;
  int failures = 0, check_count = 0, cycles = 0;
  // Plain memory and port cycles, then a peripheral write
  debp_row_type rows [5] = '{
    '{1'h0, 1'h0, 1'h0, 12'h5A3, 12'h5A3, 16'h0000},
    '{1'h1, 1'h0, 1'h0, 12'hFFF, 12'hFFF, 16'hA55A},
    '{1'h0, 1'h1, 1'h0, 12'h005, 12'hFFD, 16'h0000},
    '{1'h1, 1'h1, 1'h0, 12'h007, 12'hFFF, 16'h1234},
    '{1'h1, 1'h0, 1'h1, 12'h010, 12'h010, 16'hBEEF}};
  always #2 clk_sys = ~clk_sys;
  // Wire level: the device wins only while it enables the bus
  assign bus = data_oe ? data_out : mdl_data;
  debp_bus dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reset_in_n(reset_in_n),
    .int_in_n(int_in_n), .nmi_and_source_select_pin(nmi_pin), .code_protect_bit(protect),
    .global_interrupt_mask(mask), .req_valid(req_valid), .req_write(req_write),
    .req_port(req_port), .req_periph(req_periph), .req_addr(req_addr),
    .req_wdata(req_wdata), .pc_step(pc_step), .int_ack(int_ack), .data_line_in(bus),
    .program_address_line(addr), .addr_oe(addr_oe), .data_line_out(data_out),
    .data_oe(data_oe), .write_n(write_n), .read_n(read_n), .req_done(req_done),
    .rd_data(rd_data), .req_denied(req_denied), .int_pending(int_p), .nmi_pending(nmi_p),
    .program_source_select(src), .cpu_in_reset(in_rst), .pc(pc));
  debp_mem_model mdl_u (.clk_sys(clk_sys), .read_n(read_n), .program_address_line(addr),
    .mem_data(mdl_data));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // One request, watched cycle by cycle until done
  task automatic run_row(input debp_row_type r, input logic dn);
    logic rd, wr, oe, done, den;
    rd = 1'h0;
    wr = 1'h0;
    oe = 1'h0;
    done = 1'h0;
    den = 1'h0;
    {req_valid, req_write, req_port, req_periph} = {1'h1, r.w, r.p, r.ph};
    req_addr = r.a;
    req_wdata = r.d;
    @(negedge clk_sys);
    req_valid = 1'h0;
    for (int i = 0; i < 8 && !done; i++) begin
      rd |= !read_n; wr |= !write_n; oe |= data_oe;
      check("strobes", {15'h0000, read_n | write_n}, 16'h0001);
      if (data_oe) check("data out", data_out, r.d);
      if (!r.ph) check("data enable", {15'h0000, data_oe}, {15'h0000, !write_n});
      if (!read_n || !write_n) check("address", {4'h0, addr}, {4'h0, r.ea});
      if (req_done) begin
        done = 1'h1;
        den = req_denied;
        if (!r.w && !dn) check("read data", rd_data, {4'hC, r.ea});
      end else @(negedge clk_sys);
    end
    check("done", {15'h0000, done}, 16'h0001);
    check("denied", {15'h0000, den}, {15'h0000, dn});
    check("read seen", {15'h0000, rd}, {15'h0000, !r.w && !dn});
    check("write seen", {15'h0000, wr}, {15'h0000, r.w && !r.ph});
    check("oe seen", {15'h0000, oe}, {15'h0000, r.w});
  endtask
  // Hang guard well above the expected run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    waitn(5);
    sys_rst = 1'h0;
    waitn(4);
    check("addr enable", {15'h0000, addr_oe}, 16'h0001);
    check("source", {15'h0000, src}, 16'h0001);
    foreach (rows[i]) begin
      run_row(rows[i], 1'h0);
      $display("test row %0d done", i);
    end
    pc_step = 1'h1;
    @(negedge clk_sys);
    pc_step = 1'h0;
    waitn(1);
    check("pc step", {4'h0, pc}, 16'h0001);
    // Board reset with the strap low selects external memory
    reset_in_n = 1'h0;
    nmi_pin = 1'h0;
    waitn(5);
    check("addr float", {15'h0000, addr_oe}, 16'h0000);
    check("pc reset", {4'h0, pc}, 16'h0000);
    check("in reset", {15'h0000, in_rst}, 16'h0001);
    check("source low", {15'h0000, src}, 16'h0000);
    reset_in_n = 1'h1;
    for (int i = 0; i < 10 && in_rst !== 1'h0; i++) @(negedge clk_sys);
    waitn(1);
    nmi_pin = 1'h1;
    check("addr back", {15'h0000, addr_oe}, 16'h0001);
    $display("test reset done");
    // Protected read refused, then allowed once unprotected
    protect = 1'h1;
    run_row('{1'h0, 1'h0, 1'h0, 12'h123, 12'h123, 16'h0000}, 1'h1);
    protect = 1'h0;
    run_row('{1'h0, 1'h0, 1'h0, 12'h123, 12'h123, 16'h0000}, 1'h0);
    $display("test protect done");
    // Interrupt edge, acknowledge, mask, then the unmaskable one
    int_in_n = 1'h0;
    waitn(4);
    check("int set", {15'h0000, int_p}, 16'h0001);
    int_ack = 1'h1;
    @(negedge clk_sys);
    int_ack = 1'h0;
    {int_in_n, mask} = 2'h3;
    waitn(3);
    check("int cleared", {15'h0000, int_p}, 16'h0000);
    int_in_n = 1'h0;
    nmi_pin = 1'h0;
    waitn(4);
    check("int masked", {15'h0000, int_p}, 16'h0000);
    check("nmi set", {15'h0000, nmi_p}, 16'h0001);
    $display("test interrupts done");
    final_report();
  end
endmodule // dsp_external_bus_pin_logic_test
`default_nettype wire
